/* bench/wat_testbench.sv */
// testbench: register, output and timer checks for the week alarm timer core
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("mismatch %0t %h %h", $time, (a), (b)); end end
module testbench;
   import wat_pkg::*;
   typedef struct {logic wr; logic [4:0] a; logic [31:0] d; logic [31:0] e;} wat_row_type;
   logic mclk = 1'h0;
   logic srst = 1'h1;
   logic clk32_pin = 1'h0;
   wat_req_type bus_req = '0;
   wat_rsp_type bus_rsp;
   logic alarm_irq, wake_event, wake_decode_enable, battery_general_output;
   logic second_irq, subsecond_irq;
   int fails = 0;
   int samples_checked = 0;
   int subs = 0;
   int secs = 0;
   logic [31:0] rd;
   // reset values first, then write and read back
   wat_row_type rows [13] = '{
      '{1'h0, OFS_CONTROL, 32'h0, 32'h0}, '{1'h0, OFS_SECONDS, 32'h0, 32'h0},
      '{1'h0, OFS_COMPARE, 32'h0, 32'h0FFFFFF}, '{1'h0, OFS_PRESCALER, 32'h0, 32'h0},
      '{1'h0, OFS_RATE, 32'h0, 32'h0}, '{1'h1, OFS_CONTROL, 32'hFFFFFFFE, 32'h60},
      '{1'h1, OFS_CONTROL, 32'h1, 32'h1}, '{1'h1, OFS_COMPARE, 32'hFFFFFFFF, 32'h0FFFFFFF},
      '{1'h1, OFS_SECONDS, 32'hFFFFFFFF, 32'h0FFFFFFF}, '{1'h1, OFS_RATE, 32'hFFFFFFFF, 32'hF},
      '{1'h1, OFS_PRESCALER, 32'hFFFFFFFF, 32'h0}, '{1'h1, 5'h14, 32'hFFFFFFFF, 32'h0},
      '{1'h1, OFS_CONTROL, 32'h0, 32'h0}};

   // clock
   always #4 mclk = ~mclk;

   // count timer pulses
   always @(posedge mclk) begin
      if (subsecond_irq === 1'h1) subs++;
      if (second_irq === 1'h1) secs++;
   end

   wat_core uut (.mclk(mclk), .srst(srst), .clk32_pin(clk32_pin), .bus_req(bus_req),
      .bus_rsp(bus_rsp), .alarm_irq(alarm_irq), .wake_event(wake_event),
      .wake_decode_enable(wake_decode_enable),
      .battery_general_output(battery_general_output), .second_irq(second_irq),
      .subsecond_irq(subsecond_irq));

   // verdict and end of run
   task automatic end_sim();
      $display("compares %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // one bus access, entered and left at a rising edge
   task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      bus_req <= '{valid: 1'h1, write: wr, addr: a, wdata: d};
      @(posedge mclk);
      bus_req <= '0;
      do begin
         @(posedge mclk);
         n++;
      end while (bus_rsp.ack !== 1'h1 && n < 8);
      rd = bus_rsp.rdata;
      if (bus_rsp.ack !== 1'h1) begin
         fails++;
         end_sim();
      end
   endtask

   // slow clock ticks, one pin period each
   task automatic tick(input int n);
      repeat (n) begin
         clk32_pin <= 1'h1;
         @(posedge mclk);
         clk32_pin <= 1'h0;
         @(posedge mclk);
      end
   endtask

   // let the synchroniser settle, then read and compare
   task automatic check(input logic [4:0] a, input logic [31:0] e);
      cyc(4);
      access(1'h0, a, 32'h0);
      `CHK(rd, e)
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      `CHK(alarm_irq, 1'h0)
      foreach (rows[i]) begin
         if (rows[i].wr) access(1'h1, rows[i].a, rows[i].d);
         access(1'h0, rows[i].a, 32'h0);
         `CHK(rd, rows[i].e)
      end
      // level outputs and alarm boundary
      access(1'h1, OFS_CONTROL, 32'h20);
      `CHK({battery_general_output, wake_decode_enable, wake_event}, 3'h4)
      access(1'h1, OFS_CONTROL, 32'h40);
      cyc(2);
      `CHK({battery_general_output, wake_decode_enable, wake_event, alarm_irq}, 4'h7)
      access(1'h1, OFS_COMPARE, 32'hA);
      access(1'h1, OFS_SECONDS, 32'h9);
      cyc(2);
      `CHK({alarm_irq, wake_event}, 2'h0)
      access(1'h1, OFS_SECONDS, 32'hA);
      cyc(2);
      `CHK({alarm_irq, wake_event}, 2'h3)
      access(1'h1, OFS_CONTROL, 32'h0);
      cyc(2);
      `CHK({alarm_irq, wake_event}, 2'h2)
      // running prescaler and sub-second rates
      access(1'h1, OFS_COMPARE, 32'hFFFFFFF);
      access(1'h1, OFS_SECONDS, 32'h14);
      access(1'h1, OFS_RATE, 32'hF);
      access(1'h1, OFS_CONTROL, 32'h1);
      subs = 0;
      tick(5);
      check(OFS_PRESCALER, 32'h5);
      `CHK(subs, 5)
      access(1'h1, OFS_RATE, 32'hE);
      subs = 0;
      tick(4);
      check(OFS_PRESCALER, 32'h9);
      `CHK(subs, 2)
      access(1'h1, OFS_RATE, 32'h0);
      subs = 0;
      tick(4);
      check(OFS_PRESCALER, 32'hD);
      `CHK(subs, 0)
      // wrap into the next second, half second events on the way
      access(1'h1, OFS_RATE, 32'h1);
      subs = 0;
      secs = 0;
      tick(TICK_RATE_HZ - 13);
      check(OFS_PRESCALER, 32'h0);
      check(OFS_SECONDS, 32'h15);
      `CHK(secs, 1)
      `CHK(subs, 2)
      // stop holds the count and clears the prescaler, run resumes
      access(1'h1, OFS_CONTROL, 32'h0);
      tick(3);
      check(OFS_PRESCALER, 32'h0);
      check(OFS_SECONDS, 32'h15);
      access(1'h1, OFS_CONTROL, 32'h1);
      tick(3);
      check(OFS_PRESCALER, 32'h3);
      check(OFS_SECONDS, 32'h15);
      // mid-run reset with alarm, wake event, wake decode enable and general output raised
      access(1'h1, OFS_CONTROL, 32'h61);
      access(1'h1, OFS_COMPARE, 32'h10);
      cyc(2);
      `CHK({alarm_irq, wake_event, wake_decode_enable, battery_general_output}, 4'hF)
      srst <= 1'h1;
      cyc(2);
      srst <= 1'h0;
      cyc(1);
      `CHK({alarm_irq, wake_event, wake_decode_enable, battery_general_output}, 4'h0)
      check(OFS_CONTROL, 32'h0);
      check(OFS_PRESCALER, 32'h0);
      check(OFS_SECONDS, 32'h0);
      check(OFS_COMPARE, 32'h0FFFFFF);
      check(OFS_RATE, 32'h0);
      end_sim();
   end
endmodule // testbench
`default_nettype wire

/* pkg/wat_pkg.sv */
// package: register map, field layout, reset values and bus carriers for the week alarm timer
package wat_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_SECONDS = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_COMPARE = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_PRESCALER = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_RATE = 5'h10;
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_GPO_BIT = 5;
   localparam int unsigned CTRL_WAKE_BIT = 6;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0061;
   localparam int unsigned SEC_W = 28;
   localparam int unsigned PRESC_W = 15;
   localparam int unsigned RATE_W = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [SEC_W-1:0] SEC_RESET = 28'h000_0000;
   localparam logic [SEC_W-1:0] COMPARE_RESET = 28'h0FF_FFFF;
   localparam logic [RATE_W-1:0] RATE_RESET = 4'h0;
   localparam logic [PRESC_W-1:0] PRESC_MAX = 15'h7FFF;
   localparam logic [PRESC_W-1:0] PRESC_ZERO = 15'h0000;
   localparam int unsigned TICK_RATE_HZ = 32768;
   localparam int unsigned SYNC_STAGES = 2;

   // one register access from the internal bus
   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } wat_req_type;

   // answer to a register access
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
   } wat_rsp_type;
endpackage

/* src/wat_core.sv */
// week alarm timer core: prescaler, seconds counter, alarm and sub-second events
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1: run bit in control bit 0 starts counter and prescaler, clearing it stops them.
// R2: stopped counter holds its value and resumes from it when run is set.
// R3: run low forces prescaler to zero and idles the timer.
// R4: control bit 6 enables the wake event output; low holds it cleared.
// R5: wake enable also allows wake event decoding in the battery control logic.
// R6: control bit 5 drives the battery general output level.
// R7: 28-bit seconds counter increments each second while running; reads give value.
// R8: a seconds counter write may take up to one second to apply.
// R9: seconds and compare accesses complete whatever the run bit.
// R10: alarm and wake event assert while seconds count is at or above compare.
// R11: prescaler register is read-only, returning the 15-bit count.
// R12: 4-bit rate field sets sub-second rate; zero disables it.
// R13: rate n from 1 to 15 gives sub-second events at two to the n hertz.
// R14: prescaler counts at 32.768 kHz; wrap from maximum to zero ticks seconds.
// R15: sub-second event comes from prescaler bits picked by the rate field.
// R16: register writes complete within two slow clock cycles.
// R17: reserved bits read zero and ignore writes.
module wat_core (
   input wire logic mclk,
   input wire logic srst,
   input wire logic clk32_pin,
   input wire wat_pkg::wat_req_type bus_req,
   output var wat_pkg::wat_rsp_type bus_rsp,
   output logic alarm_irq,
   output logic wake_event,
   output logic wake_decode_enable,
   output logic battery_general_output,
   output logic second_irq,
   output logic subsecond_irq
);
   import wat_pkg::*;

   logic [SYNC_STAGES-1:0] sync_q;
   logic sync_last_q;
   logic [31:0] ctrl_q;
   logic [SEC_W-1:0] sec_q;
   logic [SEC_W-1:0] sec_d;
   logic [SEC_W-1:0] cmp_q;
   logic [PRESC_W-1:0] presc_q;
   logic [PRESC_W-1:0] presc_d;
   logic [RATE_W-1:0] rate_q;
   wat_rsp_type rsp_q;
   logic alarm_q;
   logic wake_q;
   logic second_q;
   logic subsec_q;

   // slow clock edge seen in the mclk domain
   wire slow_edge = sync_q[SYNC_STAGES-1] & ~sync_last_q;
   wire timer_run = ctrl_q[CTRL_RUN_BIT];
   wire wake_output_enable = ctrl_q[CTRL_WAKE_BIT];
   wire tick = timer_run & slow_edge;
   wire wrap = tick & (presc_q == PRESC_MAX);
   wire [PRESC_W-1:0] presc_inc = presc_q + 15'h0001;

   // address match shared by write strobes and read selection
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      addr_hit = (a == ofs);
   endfunction

   // register address decode
   wire wr = bus_req.valid & bus_req.write;
   wire rd = bus_req.valid & ~bus_req.write;
   wire sel_ctrl = addr_hit(bus_req.addr, OFS_CONTROL);
   wire sel_sec = addr_hit(bus_req.addr, OFS_SECONDS);
   wire sel_cmp = addr_hit(bus_req.addr, OFS_COMPARE);
   wire sel_presc = addr_hit(bus_req.addr, OFS_PRESCALER);
   wire sel_rate = addr_hit(bus_req.addr, OFS_RATE);
   wire sel_none = ~(sel_ctrl | sel_sec | sel_cmp | sel_presc | sel_rate); // unmapped offset
   wire wr_ctrl = wr & sel_ctrl;
   wire wr_sec = wr & sel_sec;
   wire wr_cmp = wr & sel_cmp;
   wire wr_rate = wr & sel_rate;

   // mask of prescaler low bits that must be zero for a sub-second event
   function automatic logic [PRESC_W-1:0] rate_mask(input logic [RATE_W-1:0] n);
      rate_mask = PRESC_MAX >> n;
   endfunction

   wire [PRESC_W-1:0] sub_mask = rate_mask(rate_q);
   wire subsecond_rate_select_on = (rate_q != RATE_RESET); // R12
   wire sub_hit = tick & subsecond_rate_select_on & ((presc_inc & sub_mask) == PRESC_ZERO); // R15 R13
   wire at_alarm = (sec_q >= cmp_q); // R10

   // read data selection, reserved bits zero
   wire [31:0] rd_data =
      sel_ctrl ? (ctrl_q & CTRL_MASK) :
      sel_sec ? {4'h0, sec_q} :
      sel_cmp ? {4'h0, cmp_q} :
      sel_presc ? {17'h0_0000, presc_q} :
      sel_rate ? {28'h000_0000, rate_q} : 32'h0000_0000; // R17 R11

   // prescaler: counts while running, held at zero when stopped
   assign presc_d = !timer_run ? PRESC_ZERO : (tick ? presc_inc : presc_q); // R3 R14 R1

   // seconds counter: write applies at once, else wrap increments
   assign sec_d = wr_sec ? bus_req.wdata[SEC_W-1:0] :
                  (wrap ? sec_q + 28'h000_0001 : sec_q); // R8 R9 R7 R2

   // two-flop synchroniser plus edge history
   always_ff @(posedge mclk) begin
      if (srst) begin
         sync_q <= '0;
         sync_last_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[SYNC_STAGES-2:0], clk32_pin};
         sync_last_q <= sync_q[SYNC_STAGES-1];
      end
   end

   // software registers, writes take effect in one mclk cycle
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_q <= CTRL_RESET;
         cmp_q <= COMPARE_RESET;
         rate_q <= RATE_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= bus_req.wdata & CTRL_MASK; // R16 R17 R1
         end
         if (wr_cmp) begin
            cmp_q <= bus_req.wdata[SEC_W-1:0]; // R9
         end
         if (wr_rate) begin
            rate_q <= bus_req.wdata[RATE_W-1:0]; // R12
         end
      end
   end

   // counters
   always_ff @(posedge mclk) begin
      if (srst) begin
         presc_q <= PRESC_ZERO;
         sec_q <= SEC_RESET;
      end else begin
         presc_q <= presc_d;
         sec_q <= sec_d;
      end
   end

   // bus answer, one cycle after the request
   always_ff @(posedge mclk) begin
      if (srst) begin
         rsp_q <= '0;
      end else begin
         rsp_q.ack <= bus_req.valid; // R9
         rsp_q.rdata <= rd ? rd_data : 32'h0000_0000;
      end
   end

   // event outputs
   always_ff @(posedge mclk) begin
      if (srst) begin
         alarm_q <= 1'b0;
         wake_q <= 1'b0;
         second_q <= 1'b0;
         subsec_q <= 1'b0;
      end else begin
         alarm_q <= at_alarm; // R10
         wake_q <= wake_output_enable & at_alarm; // R4 R10
         second_q <= wrap; // R14
         subsec_q <= sub_hit; // R13
      end
   end

   assign bus_rsp = rsp_q;
   assign alarm_irq = alarm_q;
   assign wake_event = wake_q;
   assign wake_decode_enable = ctrl_q[CTRL_WAKE_BIT]; // R5
   assign battery_general_output = ctrl_q[CTRL_GPO_BIT]; // R6
   assign second_irq = second_q;
   assign subsecond_irq = subsec_q;

   // checks on the timer behaviour
   chk_stop_prescaler_zero: assert property (@(posedge mclk) disable iff (srst) // R3
      !timer_run |=> (presc_q == PRESC_ZERO))
      else $error("prescaler not zero while stopped");

   chk_hold_seconds_stopped: assert property (@(posedge mclk) disable iff (srst) // R2
      (!timer_run && !wr_sec) |=> $stable(sec_q))
      else $error("seconds changed while stopped");

   chk_wrap_seconds_step: assert property (@(posedge mclk) disable iff (srst) // R14
      (wrap && !wr_sec) |=> (sec_q == $past(sec_q) + 28'h000_0001) && (presc_q == PRESC_ZERO))
      else $error("wrap did not advance seconds");

   chk_alarm_tracks_compare: assert property (@(posedge mclk) disable iff (srst) // R10
      (sec_q >= cmp_q) |=> alarm_irq)
      else $error("alarm missing at compare");

   chk_alarm_below_compare: assert property (@(posedge mclk) disable iff (srst) // R10
      (sec_q < cmp_q) |=> !alarm_irq && !wake_event)
      else $error("alarm raised below compare");

   chk_wake_gate_off: assert property (@(posedge mclk) disable iff (srst) // R4
      !wake_output_enable |=> !wake_event)
      else $error("wake event while disabled");

   chk_gpo_write_level: assert property (@(posedge mclk) disable iff (srst) // R6
      wr_ctrl |=> (battery_general_output == $past(bus_req.wdata[CTRL_GPO_BIT])))
      else $error("general output not following write");

   chk_access_ack: assert property (@(posedge mclk) disable iff (srst) // R9
      bus_req.valid |=> bus_rsp.ack)
      else $error("access not acknowledged");

   chk_presc_read_clean: assert property (@(posedge mclk) disable iff (srst) // R11
      (rd && bus_req.addr == OFS_PRESCALER) |=> (bus_rsp.rdata == {17'h0_0000, $past(presc_q)}))
      else $error("prescaler read wrong");

   chk_subsec_disabled: assert property (@(posedge mclk) disable iff (srst) // R12
      (rate_q == RATE_RESET) |=> !subsecond_irq)
      else $error("sub-second event while disabled");

   chk_subsec_fastest: assert property (@(posedge mclk) disable iff (srst) // R13
      (rate_q == 4'hF && tick) |=> subsecond_irq)
      else $error("fastest rate missed a tick");

   chk_seconds_write: assert property (@(posedge mclk) disable iff (srst) // R8
      wr_sec |=> (sec_q == $past(bus_req.wdata[SEC_W-1:0])))
      else $error("seconds write not applied");

   // checks on register writes, bus answers, pulses and sub-second phase
   chk_run_write_level: assert property (@(posedge mclk) disable iff (srst) // R1
      wr_ctrl |=> (timer_run == $past(bus_req.wdata[CTRL_RUN_BIT])))
      else $error("run bit not following write");

   chk_decode_enable_write: assert property (@(posedge mclk) disable iff (srst) // R5
      wr_ctrl |=> (wake_decode_enable == $past(bus_req.wdata[CTRL_WAKE_BIT])))
      else $error("wake decode enable not following write");

   chk_compare_write: assert property (@(posedge mclk) disable iff (srst) // R9
      wr_cmp |=> (cmp_q == $past(bus_req.wdata[SEC_W-1:0])))
      else $error("compare write not applied");

   chk_rate_write: assert property (@(posedge mclk) disable iff (srst) // R12
      wr_rate |=> (rate_q == $past(bus_req.wdata[RATE_W-1:0])))
      else $error("rate write not applied");

   chk_stop_no_pulse: assert property (@(posedge mclk) disable iff (srst) // R1 R3
      !timer_run |=> (!second_irq && !subsecond_irq))
      else $error("timer pulse while stopped");

   chk_run_prescaler_step: assert property (@(posedge mclk) disable iff (srst) // R14
      (tick && !wrap) |=> (presc_q == $past(presc_q) + 15'h0001))
      else $error("prescaler did not step on tick");

   chk_prescaler_hold_idle: assert property (@(posedge mclk) disable iff (srst) // R14
      (timer_run && !tick) |=> $stable(presc_q))
      else $error("prescaler moved without tick");

   chk_seconds_no_step: assert property (@(posedge mclk) disable iff (srst) // R7
      (!wrap && !wr_sec) |=> $stable(sec_q))
      else $error("seconds moved without wrap");

   chk_second_pulse_once: assert property (@(posedge mclk) disable iff (srst) // R14
      second_irq |=> !second_irq)
      else $error("second pulse longer than one cycle");

   chk_ack_single: assert property (@(posedge mclk) disable iff (srst) // R9
      !bus_req.valid |=> !bus_rsp.ack)
      else $error("acknowledge without access");

   chk_write_rdata_zero: assert property (@(posedge mclk) disable iff (srst) // R9
      wr |=> (bus_rsp.rdata == 32'h0000_0000))
      else $error("read data on a write");

   chk_unmapped_read_zero: assert property (@(posedge mclk) disable iff (srst) // R17
      (rd && sel_none) |=> (bus_rsp.rdata == 32'h0000_0000))
      else $error("unmapped read not zero");

   chk_seconds_read_clean: assert property (@(posedge mclk) disable iff (srst) // R7
      (rd && sel_sec) |=> (bus_rsp.rdata == {4'h0, $past(sec_q)}))
      else $error("seconds read wrong");

   chk_subsec_half_second: assert property (@(posedge mclk) disable iff (srst) // R13
      (tick && rate_q == 4'h1 && presc_q[13:0] == 14'h3FFF) |=> subsecond_irq)
      else $error("half second event missing");

   chk_subsec_half_quiet: assert property (@(posedge mclk) disable iff (srst) // R13 R15
      (tick && rate_q == 4'h1 && presc_q[13:0] != 14'h3FFF) |=> !subsecond_irq)
      else $error("half second event out of phase");

   chk_subsec_even_step: assert property (@(posedge mclk) disable iff (srst) // R13
      (tick && rate_q == 4'hE && presc_q[0]) |=> subsecond_irq)
      else $error("rate fourteen event missing");

   chk_wake_follows_alarm: assert property (@(posedge mclk) disable iff (srst) // R4
      (wake_output_enable && sec_q >= cmp_q) |=> wake_event)
      else $error("wake event missing while enabled");

   chk_gpo_hold: assert property (@(posedge mclk) disable iff (srst) // R6
      !wr_ctrl |=> $stable(battery_general_output))
      else $error("general output changed without write");

   // main scenarios
   cov_second_wrap: cover property (@(posedge mclk) disable iff (srst) wrap);
   cov_alarm_rise: cover property (@(posedge mclk) disable iff (srst) $rose(alarm_irq));
   cov_wake_event: cover property (@(posedge mclk) disable iff (srst) $rose(wake_event));
   cov_subsec_pulse: cover property (@(posedge mclk) disable iff (srst)
      subsecond_irq && rate_q == 4'h1);
   cov_run_resume: cover property (@(posedge mclk) disable iff (srst)
      $rose(timer_run) && sec_q != SEC_RESET);
endmodule // wat_core
`default_nettype wire
